// File: rtl/sarc_cfg.svh
// Constants for the converter control block
// How it works
// - Config bit selects eight-bit mode, else ten-bit
// - Eight-bit mode resolves only upper eight bits
// - Eight-bit conversion ends two SAR clocks sooner
// - Eight-bit results carry bottom two bits 00
// - Low result byte reads 0x00 in eight-bit
// - Done flag per conversion or burst; software clears
// - Burst start launches repeat-count back-to-back conversions, except one per external-pin trigger
// - Burst power-down after burst unless enable set
`ifndef SARC_CFG_SVH
`define SARC_CFG_SVH
// ==========================================
// Register addresses
`define SARC_ADDR_CTRL 8'hE8
`define SARC_ADDR_CFG 8'hBC
`define SARC_ADDR_RES_H 8'hBE
`define SARC_ADDR_RES_L 8'hBD
`define SARC_ADDR_REPEAT 8'hBA
// ==========================================
// Field positions
`define SARC_CTRL_EN 7
`define SARC_CTRL_BURST 6
`define SARC_CTRL_DONE 5
`define SARC_CTRL_START 4
`define SARC_CTRL_WIN 3
`define SARC_CFG_8BIT 2
`define SARC_CFG_DIV_LSB 3
// ==========================================
// Reset values and codes
`define SARC_CTRL_RESET 8'h00
`define SARC_CFG_RESET 8'hF8
`define SARC_REPEAT_RESET 3'h0
`define SARC_SRC_SW 3'h0
`define SARC_SRC_EXT 3'h4
// ==========================================
// Timing
`define SARC_CLK_NS 40
`define SARC_PWRUP_NS 2000
`define SARC_PWRUP_CYC ((`SARC_PWRUP_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
`endif

// File: rtl/sarc_pkg.sv
// Types for the converter control block
package sarc_pkg;
  typedef enum logic [1:0] {SARC_IDLE, SARC_PWRUP, SARC_CONV} sarc_phase_type;
  typedef enum logic {SARC_SEQ_IDLE, SARC_SEQ_RUN} sarc_seq_phase_type;

  typedef struct packed {
    sarc_seq_phase_type phase;
    logic [3:0] idx;
    logic [9:0] code;
    logic [9:0] result;
    logic done;
  } sarc_seq_state_type;

  typedef struct packed {
    logic en;
    logic burst;
    logic done;
    logic win;
    logic [2:0] src;
    logic [7:0] cfg;
    logic [2:0] repeat_code;
    logic [2:0] ext_sync;
    logic ext_lvl;
    logic [4:0] div_cnt;
    logic tick;
    sarc_phase_type phase;
    logic [7:0] pu_cnt;
    logic [6:0] left;
    logic [6:0] acc;
    logic start;
    logic [9:0] result;
    logic [7:0] rdata;
  } sarc_state_type;
endpackage

// File: rtl/sarc_seq_if.sv
// Link between control and approximation sequencer
`timescale 1ns/1ns
interface sarc_seq_if;
  logic start;
  logic eight_bit;
  logic tick;
  logic comp;
  logic done;
  logic [9:0] trial;
  logic [9:0] result;
  modport ctl (output start, eight_bit, tick, comp, input done, trial, result);
  modport seq (input start, eight_bit, tick, comp, output done, trial, result);
endinterface

// File: rtl/sarc_seq.sv
// Successive approximation bit sequencer
`timescale 1ns/1ns
module sarc_seq (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  sarc_seq_if.seq bus
);
  import sarc_pkg::*;
  sarc_seq_state_type st;
  sarc_seq_state_type next_st;
  logic [3:0] last_idx;

  assign bus.done = st.done;
  assign bus.trial = st.code;
  assign bus.result = st.result;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    last_idx = bus.eight_bit ? 4'h2 : 4'h0;
    case (st.phase)
      SARC_SEQ_IDLE: begin
        if (bus.start) begin
          next_st.phase = SARC_SEQ_RUN;
          next_st.idx = 4'h9;
          next_st.code = 10'h200;
        end
      end
      SARC_SEQ_RUN: begin
        if (bus.tick) begin
          next_st.code[st.idx] = bus.comp;
          if (st.idx == last_idx) begin
            next_st.phase = SARC_SEQ_IDLE;
            next_st.done = 1'b1;
            next_st.result = next_st.code & {8'hFF, {2{~bus.eight_bit}}};
            next_st.code = 10'h000;
          end else begin
            next_st.idx = st.idx - 4'h1;
            next_st.code[st.idx - 4'h1] = 1'b1;
          end
        end
      end
      default: next_st.phase = SARC_SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // sarc_seq

// File: rtl/sarc_top.sv
// Converter control, eight-bit mode and register file
`timescale 1ns/1ns
`include "sarc_cfg.svh"
module sarc_top #(
  parameter int PWRUP_CYC = `SARC_PWRUP_CYC
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic [2:0] timer_ovf_in,
  input wire logic external_convert_start_in,
  input wire logic comp_in,
  input wire logic window_hit_in,
  output logic [9:0] dac_trial_out,
  output logic [9:0] result_out,
  output logic conversion_done_flag_out,
  output logic window_match_flag_out,
  output logic busy_out,
  output logic converter_powered_out
);
  import sarc_pkg::*;
  localparam logic [7:0] CTRL_RST = `SARC_CTRL_RESET;
  sarc_state_type st;
  sarc_state_type next_st;
  sarc_seq_if seq_bus ();
  logic wr_ctrl;
  logic trig;
  logic ext_rise;
  logic [6:0] rep_n;
  logic [6:0] acc_inc;
  logic set_done;
  logic [7:0] ctrl_rd;
  logic wr_cfg;
  logic wr_rep;
  logic ext_stable;
  logic [4:0] div_max;
  logic conv_go;
  logic burst_multi;

  sarc_seq u_seq (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .bus(seq_bus.seq)
  );

  assign seq_bus.start = st.start;
  assign seq_bus.eight_bit = st.cfg[`SARC_CFG_8BIT];
  assign seq_bus.tick = st.tick;
  assign seq_bus.comp = comp_in;

  assign sfr_rdata_out = st.rdata;
  assign dac_trial_out = seq_bus.trial;
  assign result_out = st.result;
  assign conversion_done_flag_out = st.done;
  assign window_match_flag_out = st.win;
  assign busy_out = (st.phase != SARC_IDLE);
  assign converter_powered_out = st.en | (st.phase != SARC_IDLE);

  // ==========================================
  // Repeat count decode
  always_comb begin
    case (st.repeat_code)
      3'h0: rep_n = 7'h01;
      3'h1: rep_n = 7'h04;
      3'h2: rep_n = 7'h08;
      3'h3: rep_n = 7'h10;
      3'h4: rep_n = 7'h20;
      3'h5: rep_n = 7'h40;
      default: rep_n = 7'h01;
    endcase
  end

  // ==========================================
  // Address decode
  assign wr_ctrl = sfr_wr_in && (sfr_addr_in == `SARC_ADDR_CTRL);
  assign wr_cfg = sfr_wr_in && (sfr_addr_in == `SARC_ADDR_CFG);
  assign wr_rep = sfr_wr_in && (sfr_addr_in == `SARC_ADDR_REPEAT);
  assign div_max = st.cfg[7:`SARC_CFG_DIV_LSB];

  // ==========================================
  // Trigger selection
  assign ext_stable = (st.ext_sync[1] == st.ext_sync[2]);
  assign ext_rise = ext_stable && st.ext_sync[2] && !st.ext_lvl;
  always_comb begin
    case (st.src)
      `SARC_SRC_SW: trig = wr_ctrl && sfr_wdata_in[`SARC_CTRL_START];
      3'h1: trig = timer_ovf_in[0];
      3'h2: trig = timer_ovf_in[1];
      3'h3: trig = timer_ovf_in[2];
      `SARC_SRC_EXT: trig = ext_rise;
      default: trig = 1'b0;
    endcase
  end

  assign conv_go = trig && (st.burst || st.en);
  assign burst_multi = st.burst && (st.src != `SARC_SRC_EXT);
  assign acc_inc = st.acc + 7'h01;
  assign set_done = seq_bus.done && (!st.burst || (acc_inc == rep_n));

  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`SARC_CTRL_EN] = st.en;
    ctrl_rd[`SARC_CTRL_BURST] = st.burst;
    ctrl_rd[`SARC_CTRL_DONE] = st.done;
    ctrl_rd[`SARC_CTRL_START] = busy_out;
    ctrl_rd[`SARC_CTRL_WIN] = st.win;
    ctrl_rd[2:0] = st.src;
  end

  // ==========================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.start = 1'b0;

    // ==========================================
    // Pin filter and SAR clock divider
    next_st.ext_sync = {st.ext_sync[1:0], external_convert_start_in};
    if (ext_stable) begin
      next_st.ext_lvl = st.ext_sync[2];
    end
    if (st.div_cnt >= div_max) begin
      next_st.div_cnt = 5'h00;
      next_st.tick = 1'b1;
    end else begin
      next_st.div_cnt = st.div_cnt + 5'h01;
      next_st.tick = 1'b0;
    end

    // ==========================================
    // Register writes
    if (wr_ctrl) begin
      next_st.en = sfr_wdata_in[`SARC_CTRL_EN];
      next_st.burst = sfr_wdata_in[`SARC_CTRL_BURST];
      next_st.done = sfr_wdata_in[`SARC_CTRL_DONE];
      next_st.win = sfr_wdata_in[`SARC_CTRL_WIN];
      next_st.src = sfr_wdata_in[2:0];
    end
    if (wr_cfg) begin
      next_st.cfg = sfr_wdata_in;
    end
    if (wr_rep) begin
      next_st.repeat_code = sfr_wdata_in[2:0];
      next_st.acc = 7'h00;
    end

    // ==========================================
    // Conversion sequencing
    case (st.phase)
      SARC_IDLE: begin
        if (conv_go) begin
          next_st.left = burst_multi ? rep_n : 7'h01;
          if (st.burst && !st.en) begin
            next_st.phase = SARC_PWRUP;
            next_st.pu_cnt = 8'(PWRUP_CYC);
          end else begin
            next_st.phase = SARC_CONV;
            next_st.start = 1'b1;
          end
        end
      end
      SARC_PWRUP: begin
        if (st.pu_cnt <= 8'h01) begin
          next_st.phase = SARC_CONV;
          next_st.start = 1'b1;
        end else begin
          next_st.pu_cnt = st.pu_cnt - 8'h01;
        end
      end
      SARC_CONV: begin
        if (seq_bus.done) begin
          next_st.result = seq_bus.result;
          next_st.acc = set_done ? 7'h00 : acc_inc;
          if (set_done) begin
            next_st.done = 1'b1;
            if (window_hit_in) begin
              next_st.win = 1'b1;
            end
          end
          if (st.left > 7'h01) begin
            next_st.left = st.left - 7'h01;
            next_st.start = 1'b1;
          end else begin
            next_st.left = 7'h00;
            next_st.phase = SARC_IDLE;
          end
        end
      end
      default: next_st.phase = SARC_IDLE;
    endcase

    // ==========================================
    // Register reads
    if (sfr_rd_in) begin
      case (sfr_addr_in)
        `SARC_ADDR_CTRL: next_st.rdata = ctrl_rd;
        `SARC_ADDR_CFG: next_st.rdata = st.cfg;
        `SARC_ADDR_RES_H: next_st.rdata = st.result[9:2];
        `SARC_ADDR_RES_L: next_st.rdata = st.cfg[`SARC_CFG_8BIT] ? 8'h00 :
          {st.result[1:0], 6'h00};
        `SARC_ADDR_REPEAT: next_st.rdata = {5'h00, st.repeat_code};
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      st <= '0;
      st.cfg <= `SARC_CFG_RESET;
      st.repeat_code <= `SARC_REPEAT_RESET;
      {st.en, st.burst, st.done, st.win, st.src} <= {CTRL_RST[7:5], CTRL_RST[3:0]}; // No bit 4
    end else begin
      st <= next_st;
    end
  end
endmodule // sarc_top

// File: testbench/sarc_top_props.sv
// Checker for converter control ports
`timescale 1ns/1ns
module sarc_top_props (
  input logic clk_sys_in,
  input logic srst_in,
  input logic [7:0] sfr_addr_in,
  input logic sfr_wr_in,
  input logic sfr_rd_in,
  input logic [7:0] sfr_wdata_in,
  input logic [7:0] sfr_rdata_out,
  input logic [9:0] dac_trial_out,
  input logic [9:0] result_out,
  input logic conversion_done_flag_out,
  input logic busy_out,
  input logic converter_powered_out
);
  // ==========================================
  // Mode tracking
  logic m8;
  logic en;
  logic burst;
  logic [2:0] src;
  logic wc;
  assign wc = sfr_wr_in && sfr_addr_in == 8'hE8;
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      m8 <= 1'b0;
      en <= 1'b0;
      burst <= 1'b0;
      src <= 3'h0;
    end else begin
      if (sfr_wr_in && sfr_addr_in == 8'hBC) m8 <= sfr_wdata_in[2];
      if (wc) en <= sfr_wdata_in[7];
      if (wc) burst <= sfr_wdata_in[6];
      if (wc) src <= sfr_wdata_in[2:0];
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  // ==========================================
  // Properties
  property p_swst; wc && sfr_wdata_in[4] && (en || burst) && src == 3'h0 && !busy_out
    |=> busy_out; endproperty
  a_swst: assert property (p_swst) else $error("start lost");
  property p_trial; m8 && $changed(dac_trial_out) |-> dac_trial_out[1:0] == 2'b00; endproperty
  a_trial: assert property (p_trial) else $error("low trial");
  property p_lsb; m8 && $changed(result_out) |-> result_out[1:0] == 2'b00; endproperty
  a_lsb: assert property (p_lsb) else $error("low bits");
  property p_lowrd; sfr_rd_in && sfr_addr_in == 8'hBD && m8 |=> sfr_rdata_out == 8'h00;
    endproperty
  a_lowrd: assert property (p_lowrd) else $error("low byte");
  property p_hold; $fell(conversion_done_flag_out) |-> $past(wc && !sfr_wdata_in[5]);
    endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_end; $rose(conversion_done_flag_out) && !$past(wc && sfr_wdata_in[5])
    |-> $fell(busy_out); endproperty
  a_end: assert property (p_end) else $error("flag early");
  property p_off; !busy_out && !en |-> !converter_powered_out; endproperty
  a_off: assert property (p_off) else $error("power on");
  property p_on; busy_out || en |-> converter_powered_out; endproperty
  a_on: assert property (p_on) else $error("power off");
endmodule // sarc_top_props
bind sarc_top sarc_top_props u_sarc_top_props (.clk_sys_in, .srst_in, .sfr_addr_in,
  .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out, .dac_trial_out, .result_out,
  .conversion_done_flag_out, .busy_out, .converter_powered_out);

// File: testbench/test_sarc_top.sv
// Self-checking bench for converter control
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t bad", $time); end end
module test_sarc_top;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [2:0] tovf = 3'h0;
  logic ext = 1'b0;
  logic [9:0] vin = 10'h2A7;
  logic [9:0] tprev = 10'h000;
  logic [7:0] rdata;
  logic [9:0] trial;
  logic [9:0] res;
  logic flag;
  logic busy;
  logic pwr;
  logic whit = 1'b0;
  logic winf;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int nconv = 0;
  int d10;
  int d8;
  int d;
  always #20 clk_sys_in = ~clk_sys_in;
  sarc_top #(.PWRUP_CYC(3)) u_sarc_top (.clk_sys_in, .srst_in, .sfr_addr_in(addr),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wd), .sfr_rdata_out(rdata),
    .timer_ovf_in(tovf), .external_convert_start_in(ext), .comp_in(vin >= trial),
    .window_hit_in(whit), .dac_trial_out(trial), .result_out(res),
    .conversion_done_flag_out(flag), .window_match_flag_out(winf), .busy_out(busy),
    .converter_powered_out(pwr));
  // ==========================================
  // Conversion counter and timeout
  always @(posedge clk_sys_in) begin
    cyc++;
    if (trial === 10'h200 && tprev !== 10'h200) nconv++;
    tprev = trial;
    if (cyc == 30000) begin
      n_fail++;
      test_done();
    end
  end
  // ==========================================
  // Tasks
  task test_done();
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wrr(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk_sys_in);
    #1 addr = a;
    wd = x;
    wr = 1'b1;
    @(posedge clk_sys_in);
    #1 wr = 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    #1 addr = a;
    rd = 1'b1;
    @(posedge clk_sys_in);
    #1 rd = 1'b0;
    `CHK(rdata, e)
  endtask
  task run(output int n);
    int w;
    w = 0;
    n = 0;
    while (busy !== 1'b1 && w < 40) begin
      @(posedge clk_sys_in);
      #1 w++;
    end
    while (busy === 1'b1 && n < 3000) begin
      @(posedge clk_sys_in);
      #1 n++;
    end
  endtask
  task wflag();
    int w;
    w = 0;
    while (!(flag === 1'b1 && busy === 1'b0) && w < 3000) begin
      @(posedge clk_sys_in);
      #1 w++;
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys_in);
    #1 srst_in = 1'b0;
    rdc(8'hE8, 8'h00);
    rdc(8'hBC, 8'hF8);
    rdc(8'h55, 8'h00);
    wrr(8'hBC, 8'h00);
    wrr(8'hE8, 8'h80);
    wrr(8'hE8, 8'h90);
    run(d10);
    `CHK(res, vin)
    rdc(8'hE8, 8'hA0);
    rdc(8'hBD, {vin[1:0], 6'h00});
    wrr(8'hE8, 8'h80);
    `CHK(flag, 1'b0)
    wrr(8'hBC, 8'h04);
    wrr(8'hE8, 8'h90);
    run(d8);
    `CHK(res, {vin[9:2], 2'b00})
    `CHK(d8, d10 - 2)
    rdc(8'hBD, 8'h00);
    rdc(8'hBE, vin[9:2]);
    wrr(8'hE8, 8'h00);
    wrr(8'hE8, 8'h10);
    run(d);
    `CHK(busy, 1'b0)
    for (int k = 1; k < 4; k++) begin
      vin = 10'h155 + 10'(k);
      wrr(8'hE8, 8'h80 | 8'(k));
      #40 tovf = 3'h1 << (k - 1);
      #40 tovf = 3'h0;
      run(d);
      `CHK(res, {vin[9:2], 2'b00})
    end
    vin = 10'h3C8;
    wrr(8'hE8, 8'h84);
    ext = 1'b1;
    whit = 1'b1;
    run(d);
    ext = 1'b0;
    whit = 1'b0;
    `CHK(res, {vin[9:2], 2'b00})
    `CHK(winf, 1'b1)
    wrr(8'hBC, 8'h00);
    wrr(8'hBA, 8'h01);
    vin = 10'h2A7;
    nconv = 0;
    wrr(8'hE8, 8'h40);
    wrr(8'hE8, 8'h50);
    wflag();
    `CHK(nconv, 4)
    `CHK(res, vin)
    `CHK(pwr, 1'b0)
    `CHK(winf, 1'b0)
    wrr(8'hE8, 8'hD0);
    wflag();
    `CHK(pwr, 1'b1)
    test_done();
  end
endmodule // test_sarc_top
